// ### hdl/sdt_pkg.sv
package sdt_pkg;

    // Register indices; the byte address on the bus is four times these
    localparam logic [7:0] SDT_IDX_HIGH = 8'hf0;
    localparam logic [7:0] SDT_IDX_LOW = 8'hf1;
    localparam logic [7:0] SDT_IDX_PSC = 8'hf2;
    localparam logic [7:0] SDT_IDX_CTRL = 8'hf3;
    localparam logic [7:0] SDT_IDX_STRIDE = 8'h08;
    localparam int SDT_IDX_LSB = 2;
    localparam int SDT_IDX_W = 8;
    localparam int SDT_MAX_TIMERS = 2;

    localparam logic [7:0] SDT_RST_HIGH = 8'hff;
    localparam logic [7:0] SDT_RST_LOW = 8'hff;
    localparam logic [7:0] SDT_RST_PSC = 8'hff;
    localparam logic [7:0] SDT_RST_CTRL = 8'h14;

    // Control register fields
    localparam int SDT_B_RUN = 7;
    localparam int SDT_B_SINGLE = 6;
    localparam int SDT_B_INMD = 4;
    localparam int SDT_B_INPUT_SECTION_ENABLE = 3;
    localparam int SDT_B_INTERRUPT_SOURCE_SELECT = 2;
    localparam int SDT_B_OUTMD = 0;
    localparam int SDT_B_OUT_LO = 0;

    // Core internal clock divided by four
    localparam logic [1:0] SDT_DIV4_LAST = 2'h3;

    localparam logic [1:0] SDT_RESP_OKAY = 2'h0;
    localparam logic [1:0] SDT_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        SDT_IN_EVENT,
        SDT_IN_GATED,
        SDT_IN_TRIG,
        SDT_IN_RETRIG
    } sdt_inmode_t;

    typedef enum logic [1:0] {
        SDT_OUT_NONE,
        SDT_OUT_SQUARE,
        SDT_OUT_PWM_LO,
        SDT_OUT_PWM_HI
    } sdt_outmode_t;

endpackage : sdt_pkg

// ### hdl/sdt_regbus_if.sv
`timescale 1ns/1ns
interface sdt_regbus_if;
    logic wr_stb;
    logic [7:0] wr_idx;
    logic [7:0] wr_data;
    logic wr_ok;
    logic [7:0] rd_idx;
    logic [7:0] rd_data;
    logic rd_ok;

    modport slave (
        output wr_stb,
        output wr_idx,
        output wr_data,
        output rd_idx,
        input wr_ok,
        input rd_data,
        input rd_ok
    );

    modport regs (
        input wr_stb,
        input wr_idx,
        input wr_data,
        input rd_idx,
        output wr_ok,
        output rd_data,
        output rd_ok
    );
endinterface : sdt_regbus_if

// ### hdl/sdt_axil.sv
`timescale 1ns/1ns
module sdt_axil
    import sdt_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] s_axil_awaddr,
    input wire logic s_axil_awvalid,
    output logic s_axil_awready,
    input wire logic [31:0] s_axil_wdata,
    input wire logic [3:0] s_axil_wstrb,
    input wire logic s_axil_wvalid,
    output logic s_axil_wready,
    output logic [1:0] s_axil_bresp,
    output logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic [ADDR_W-1:0] s_axil_araddr,
    input wire logic s_axil_arvalid,
    output logic s_axil_arready,
    output logic [31:0] s_axil_rdata,
    output logic [1:0] s_axil_rresp,
    output logic s_axil_rvalid,
    input wire logic s_axil_rready,
    sdt_regbus_if.slave rb
);

    localparam int TOP_LSB = SDT_IDX_LSB + SDT_IDX_W;

    logic aw_have_r;
    logic w_have_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [7:0] wdata_r;
    logic wlane_r;
    logic do_write;
    logic aw_in_range;
    logic ar_in_range;

    generate
        if (ADDR_W < TOP_LSB + 1) begin : g_bad_addr_w
            $error("sdt_axil: ADDR_W too small for the register map");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Write channel: address and data taken in either order
    assign s_axil_awready = !aw_have_r && !s_axil_bvalid;
    assign s_axil_wready = !w_have_r && !s_axil_bvalid;
    assign do_write = aw_have_r && w_have_r && !s_axil_bvalid;
    assign aw_in_range = awaddr_r[ADDR_W-1:TOP_LSB] == '0;

    assign rb.wr_idx = awaddr_r[SDT_IDX_LSB +: SDT_IDX_W];
    assign rb.wr_data = wdata_r;
    // Only lane 0 carries register bits; other lanes are accepted and dropped
    assign rb.wr_stb = do_write && aw_in_range && wlane_r;

    always_ff @(posedge mclk) begin
        if (reset) begin
            aw_have_r <= 1'b0;
            awaddr_r <= '0;
        end else if (s_axil_awvalid && s_axil_awready) begin
            aw_have_r <= 1'b1;
            awaddr_r <= s_axil_awaddr;
        end else if (do_write) begin
            aw_have_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            w_have_r <= 1'b0;
            wdata_r <= 8'h00;
            wlane_r <= 1'b0;
        end else if (s_axil_wvalid && s_axil_wready) begin
            w_have_r <= 1'b1;
            wdata_r <= s_axil_wdata[7:0];
            wlane_r <= s_axil_wstrb[0];
        end else if (do_write) begin
            w_have_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            s_axil_bvalid <= 1'b0;
            s_axil_bresp <= SDT_RESP_OKAY;
        end else if (do_write) begin
            s_axil_bvalid <= 1'b1;
            s_axil_bresp <= (aw_in_range && rb.wr_ok) ? SDT_RESP_OKAY
                                                      : SDT_RESP_SLVERR;
        end else if (s_axil_bready) begin
            s_axil_bvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read channel: data captured on the address edge
    assign s_axil_arready = !s_axil_rvalid;
    assign rb.rd_idx = s_axil_araddr[SDT_IDX_LSB +: SDT_IDX_W];
    assign ar_in_range = s_axil_araddr[ADDR_W-1:TOP_LSB] == '0;

    always_ff @(posedge mclk) begin
        if (reset) begin
            s_axil_rvalid <= 1'b0;
            s_axil_rdata <= 32'h0000_0000;
            s_axil_rresp <= SDT_RESP_OKAY;
        end else if (s_axil_arvalid && s_axil_arready) begin
            s_axil_rvalid <= 1'b1;
            if (ar_in_range && rb.rd_ok) begin
                s_axil_rdata <= {24'h00_0000, rb.rd_data};
                s_axil_rresp <= SDT_RESP_OKAY;
            end else begin
                s_axil_rdata <= 32'h0000_0000;
                s_axil_rresp <= SDT_RESP_SLVERR;
            end
        end else if (s_axil_rready) begin
            s_axil_rvalid <= 1'b0;
        end
    end

endmodule : sdt_axil

// ### hdl/sdt_top.sv
`timescale 1ns/1ns
// Summary of operation
// - 16-bit down counter behind 8-bit prescaler
// - Clock from internal/4, oscillator, or pin
// - End-of-count when counter underflows past zero
// - Run bit starts next cycle, clear halts
// - Restart resumes, or loads constant written meanwhile
// - Constants at next end-of-count; prescaler immediately
// - High, low, prescaler registers reset all ones
// - Single mode: stop, reload, clear run bit
// - Continuous mode reloads and keeps counting
// - Single bit writable anytime, with start together
// - Input disabled: internal/4 only, pin ignored
// - Event mode counts falling pin edges, spaced
// - Gated mode counts internal/4 while pin high
// - Trigger mode waits run then falling edge
// - Retrigger edge while running restarts from constants
// - Oscillator variant: event mode counts oscillator clock
// - Output mode 00 drives pin high
// - Output mode 01 toggles pin each end-of-count
// - PWM mode copies lower bit at end-of-count
// - Interrupt select: timer end-of-count or external pin
// - Counter writes set constant, reads give live
// - Prescaler divides by value plus one; reads programmed
// - Control resets 14h with documented bit layout
module sdt_top
    import sdt_pkg::*;
#(
    parameter int N_TIMERS = 2,
    parameter int ADDR_W = 12,
    // Per instance: event mode counts the oscillator-derived clock in place of the input pin
    parameter logic [N_TIMERS-1:0] OSC_VARIANT = '0
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] s_axil_awaddr,
    input wire logic s_axil_awvalid,
    output logic s_axil_awready,
    input wire logic [31:0] s_axil_wdata,
    input wire logic [3:0] s_axil_wstrb,
    input wire logic s_axil_wvalid,
    output logic s_axil_wready,
    output logic [1:0] s_axil_bresp,
    output logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic [ADDR_W-1:0] s_axil_araddr,
    input wire logic s_axil_arvalid,
    output logic s_axil_arready,
    output logic [31:0] s_axil_rdata,
    output logic [1:0] s_axil_rresp,
    output logic s_axil_rvalid,
    input wire logic s_axil_rready,
    input wire logic oscillator_derived_clock,
    input wire logic [N_TIMERS-1:0] timer_input_pin,
    input wire logic [N_TIMERS-1:0] ext_irq_pin,
    output logic [N_TIMERS-1:0] timer_output_pin,
    output logic [N_TIMERS-1:0] irq_channel
);

    sdt_regbus_if rb ();

    logic [1:0] div_r;
    logic div_tick;
    logic osc_d_r;
    logic osc_rise;
    logic [N_TIMERS-1:0] wr_hit;
    logic [N_TIMERS-1:0] rd_hit;
    logic [7:0] rd_val [N_TIMERS];

    generate
        if (N_TIMERS < 1 || N_TIMERS > SDT_MAX_TIMERS) begin : g_bad_n
            $error("sdt_top: N_TIMERS must be 1 or 2");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Bus slave
    sdt_axil #(
        .ADDR_W(ADDR_W)
    ) u_axil (
        .mclk(mclk),
        .reset(reset),
        .s_axil_awaddr(s_axil_awaddr),
        .s_axil_awvalid(s_axil_awvalid),
        .s_axil_awready(s_axil_awready),
        .s_axil_wdata(s_axil_wdata),
        .s_axil_wstrb(s_axil_wstrb),
        .s_axil_wvalid(s_axil_wvalid),
        .s_axil_wready(s_axil_wready),
        .s_axil_bresp(s_axil_bresp),
        .s_axil_bvalid(s_axil_bvalid),
        .s_axil_bready(s_axil_bready),
        .s_axil_araddr(s_axil_araddr),
        .s_axil_arvalid(s_axil_arvalid),
        .s_axil_arready(s_axil_arready),
        .s_axil_rdata(s_axil_rdata),
        .s_axil_rresp(s_axil_rresp),
        .s_axil_rvalid(s_axil_rvalid),
        .s_axil_rready(s_axil_rready),
        .rb(rb.slave)
    );

    assign rb.wr_ok = |wr_hit;
    assign rb.rd_ok = |rd_hit;

    always_comb begin
        rb.rd_data = 8'h00;
        for (int k = 0; k < N_TIMERS; k++) begin
            if (rd_hit[k]) begin
                rb.rd_data = rb.rd_data | rd_val[k];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared time bases
    // Core internal clock divided by four; mclk stands for the core clock
    always_ff @(posedge mclk) begin
        if (reset) begin
            div_r <= 2'h0;
        end else begin
            div_r <= div_r + 2'h1;
        end
    end

    assign div_tick = div_r == SDT_DIV4_LAST;

    always_ff @(posedge mclk) begin
        if (reset) begin
            osc_d_r <= 1'b0;
        end else begin
            osc_d_r <= oscillator_derived_clock;
        end
    end

    assign osc_rise = oscillator_derived_clock && !osc_d_r;

    ////////////////////////////////////////////////////////////////////////
    // Timer instances
    for (genvar i = 0; i < N_TIMERS; i++) begin : g_tim
        localparam logic [7:0] BASE = 8'(SDT_IDX_STRIDE * 8'(i));

        logic [7:0] ctrl_r;
        logic [15:0] const_r;
        logic [7:0] psc_r;
        logic [15:0] cnt_r;
        logic [7:0] pcnt_r;
        logic pend_r;
        logic armed_r;
        logic run_d_r;
        logic pin_d_r;
        logic tout_r;
        logic irq_r;

        logic wr_high;
        logic wr_low;
        logic wr_psc;
        logic wr_ctrl;
        logic run;
        logic start;
        logic fall;
        logic src_tick;
        logic load;
        logic adv;
        logic eoc;
        logic retrig;
        sdt_inmode_t in_mode;
        sdt_outmode_t out_mode;

        assign wr_high = rb.wr_stb && rb.wr_idx == SDT_IDX_HIGH + BASE;
        assign wr_low = rb.wr_stb && rb.wr_idx == SDT_IDX_LOW + BASE;
        assign wr_psc = rb.wr_stb && rb.wr_idx == SDT_IDX_PSC + BASE;
        assign wr_ctrl = rb.wr_stb && rb.wr_idx == SDT_IDX_CTRL + BASE;
        assign wr_hit[i] = wr_high || wr_low || wr_psc || wr_ctrl;

        assign run = ctrl_r[SDT_B_RUN];
        assign in_mode = sdt_inmode_t'(ctrl_r[SDT_B_INMD +: 2]);
        assign out_mode = sdt_outmode_t'(ctrl_r[SDT_B_OUTMD +: 2]);
        // Run bit seen one cycle after the write that sets it
        assign start = run && !run_d_r;

        ////////////////////////////////////////////////////////////////////
        // Input section
        always_ff @(posedge mclk) begin
            if (reset) begin
                pin_d_r <= 1'b1;
                run_d_r <= 1'b0;
            end else begin
                pin_d_r <= timer_input_pin[i];
                run_d_r <= run;
            end
        end

        // Edges closer than eight core clocks may be missed by the source
        assign fall = pin_d_r && !timer_input_pin[i];

        always_comb begin
            src_tick = 1'b0;
            if (!ctrl_r[SDT_B_INPUT_SECTION_ENABLE]) begin
                src_tick = div_tick;
            end else begin
                case (in_mode)
                    SDT_IN_EVENT: begin
                        if (OSC_VARIANT[i]) begin
                            src_tick = osc_rise;
                        end else begin
                            src_tick = fall;
                        end
                    end
                    SDT_IN_GATED: begin
                        src_tick = div_tick && timer_input_pin[i];
                    end
                    SDT_IN_TRIG: begin
                        src_tick = div_tick && armed_r;
                    end
                    SDT_IN_RETRIG: begin
                        src_tick = div_tick;
                    end
                    default: begin
                        src_tick = 1'b0;
                    end
                endcase
            end
        end

        // Trigger mode: armed by a falling edge only once running
        always_ff @(posedge mclk) begin
            if (reset) begin
                armed_r <= 1'b0;
            end else if (!run) begin
                armed_r <= 1'b0;
            end else if (fall) begin
                armed_r <= 1'b1;
            end
        end

        assign retrig = ctrl_r[SDT_B_INPUT_SECTION_ENABLE] && in_mode == SDT_IN_RETRIG
                        && run && fall;

        ////////////////////////////////////////////////////////////////////
        // Registers written by software
        always_ff @(posedge mclk) begin
            if (reset) begin
                const_r <= {SDT_RST_HIGH, SDT_RST_LOW};
            end else if (wr_high) begin
                const_r[15:8] <= rb.wr_data;
            end else if (wr_low) begin
                const_r[7:0] <= rb.wr_data;
            end
        end

        always_ff @(posedge mclk) begin
            if (reset) begin
                psc_r <= SDT_RST_PSC;
            end else if (wr_psc) begin
                psc_r <= rb.wr_data;
            end
        end

        // Software write wins over the single-mode stop in the same cycle
        always_ff @(posedge mclk) begin
            if (reset) begin
                ctrl_r <= SDT_RST_CTRL;
            end else if (wr_ctrl) begin
                ctrl_r <= rb.wr_data;
            end else if (eoc && ctrl_r[SDT_B_SINGLE]) begin
                ctrl_r[SDT_B_RUN] <= 1'b0;
            end
        end

        // A constant written while stopped is loaded at the restart
        always_ff @(posedge mclk) begin
            if (reset) begin
                pend_r <= 1'b0;
            end else if ((wr_high || wr_low) && !run) begin
                pend_r <= 1'b1;
            end else if (start || eoc) begin
                pend_r <= 1'b0;
            end
        end

        ////////////////////////////////////////////////////////////////////
        // Prescaler and counter
        assign load = (start && pend_r) || retrig;
        assign adv = run && src_tick && !load && !wr_psc;
        assign eoc = adv && pcnt_r == 8'h00 && cnt_r == 16'h0000;

        always_ff @(posedge mclk) begin
            if (reset) begin
                pcnt_r <= SDT_RST_PSC;
            end else if (load) begin
                pcnt_r <= psc_r;
            end else if (wr_psc) begin
                pcnt_r <= rb.wr_data;
            end else if (adv) begin
                if (pcnt_r == 8'h00) begin
                    pcnt_r <= psc_r;
                end else begin
                    pcnt_r <= pcnt_r - 8'h01;
                end
            end
        end

        // Held value is kept while stopped, so a restart resumes from it
        always_ff @(posedge mclk) begin
            if (reset) begin
                cnt_r <= {SDT_RST_HIGH, SDT_RST_LOW};
            end else if (load) begin
                cnt_r <= const_r;
            end else if (adv && pcnt_r == 8'h00) begin
                if (cnt_r == 16'h0000) begin
                    cnt_r <= const_r;
                end else begin
                    cnt_r <= cnt_r - 16'h0001;
                end
            end
        end

        ////////////////////////////////////////////////////////////////////
        // Output pin and interrupt channel
        always_ff @(posedge mclk) begin
            if (reset) begin
                tout_r <= 1'b1;
            end else begin
                case (out_mode)
                    SDT_OUT_NONE: begin
                        tout_r <= 1'b1;
                    end
                    SDT_OUT_SQUARE: begin
                        if (eoc) begin
                            tout_r <= !tout_r;
                        end
                    end
                    SDT_OUT_PWM_LO, SDT_OUT_PWM_HI: begin
                        if (eoc) begin
                            tout_r <= ctrl_r[SDT_B_OUT_LO];
                        end
                    end
                    default: begin
                        tout_r <= 1'b1;
                    end
                endcase
            end
        end

        // Switching the source can produce an edge; software masks first
        always_ff @(posedge mclk) begin
            if (reset) begin
                irq_r <= 1'b0;
            end else if (ctrl_r[SDT_B_INTERRUPT_SOURCE_SELECT]) begin
                irq_r <= ext_irq_pin[i];
            end else begin
                irq_r <= eoc;
            end
        end

        assign timer_output_pin[i] = tout_r;
        assign irq_channel[i] = irq_r;

        ////////////////////////////////////////////////////////////////////
        // Read-back
        always_comb begin
            rd_hit[i] = 1'b1;
            rd_val[i] = 8'h00;
            if (rb.rd_idx == SDT_IDX_HIGH + BASE) begin
                rd_val[i] = cnt_r[15:8];
            end else if (rb.rd_idx == SDT_IDX_LOW + BASE) begin
                rd_val[i] = cnt_r[7:0];
            end else if (rb.rd_idx == SDT_IDX_PSC + BASE) begin
                rd_val[i] = psc_r;
            end else if (rb.rd_idx == SDT_IDX_CTRL + BASE) begin
                rd_val[i] = ctrl_r;
            end else begin
                rd_hit[i] = 1'b0;
            end
        end
    end

endmodule : sdt_top

// ### testbench/sdt_top_monitor.sv
`timescale 1ns/1ns
module sdt_top_monitor
    import sdt_pkg::*;
#(
    parameter int N_TIMERS = 2,
    parameter int ADDR_W = 12
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic s_axil_awvalid,
    input wire logic s_axil_awready,
    input wire logic s_axil_wvalid,
    input wire logic s_axil_wready,
    input wire logic [1:0] s_axil_bresp,
    input wire logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic [ADDR_W-1:0] s_axil_araddr,
    input wire logic s_axil_arvalid,
    input wire logic s_axil_arready,
    input wire logic [31:0] s_axil_rdata,
    input wire logic [1:0] s_axil_rresp,
    input wire logic s_axil_rvalid,
    input wire logic s_axil_rready,
    input wire logic [N_TIMERS-1:0] timer_output_pin,
    input wire logic [N_TIMERS-1:0] irq_channel
);
    default clocking @(posedge mclk); endclocking
    default disable iff (reset);
    sequence s_wr_both;
        s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready;
    endsequence
    sequence s_rd_take;
        s_axil_arvalid && s_axil_arready;
    endsequence
    ////////////////////////////////////////////////////////////////////
    a_wr_answer: assert property (s_wr_both |-> ##[1:2] s_axil_bvalid)
        else $error("write response missing");
    a_b_holds: assert property (s_axil_bvalid && !s_axil_bready |=>
        s_axil_bvalid && $stable(s_axil_bresp)) else $error("bresp dropped");
    a_r_latency: assert property (s_rd_take |=> s_axil_rvalid)
        else $error("read data late");
    a_r_holds: assert property (s_axil_rvalid && !s_axil_rready |=>
        s_axil_rvalid && $stable(s_axil_rdata)) else $error("rdata dropped");
    a_ar_blocked: assert property (s_axil_rvalid |-> !s_axil_arready)
        else $error("address taken while data pending");
    a_rd_upper: assert property (s_axil_rvalid |->
        s_axil_rdata[31:8] == 24'h0) else $error("upper read bits set");
    a_unmapped_err: assert property ((s_rd_take and
        s_axil_araddr[ADDR_W-1:ADDR_W-2] != 2'h0) |=>
        s_axil_rresp == SDT_RESP_SLVERR && s_axil_rdata == 32'h0)
        else $error("unmapped read not refused");
    // Own disable so the reset cycle itself is the antecedent
    a_reset_idle: assert property (disable iff (1'b0) reset |=>
        !s_axil_bvalid && !s_axil_rvalid && (&timer_output_pin) &&
        irq_channel == '0) else $error("outputs not idle after reset");
endmodule : sdt_top_monitor

bind sdt_top sdt_top_monitor #(.N_TIMERS(N_TIMERS), .ADDR_W(ADDR_W))
    sdt_top_monitor_i (.*);

// ### testbench/sdt_pin_partner.sv
`timescale 1ns/1ns
module sdt_pin_partner (
    input wire logic mclk,
    output logic pin,
    output logic ext_irq
);
    initial begin
        pin = 1'b1;
        ext_irq = 1'b0;
    end
    // Edges spaced well past eight core clocks
    task automatic fall(input int cnt);
        repeat (cnt) begin
            @(posedge mclk);
            pin <= 1'b0;
            repeat (8) @(posedge mclk);
            pin <= 1'b1;
            repeat (8) @(posedge mclk);
        end
    endtask : fall
    task automatic level(input logic v);
        @(posedge mclk);
        pin <= v;
    endtask : level
    task automatic ext(input logic v);
        @(posedge mclk);
        ext_irq <= v;
    endtask : ext
endmodule : sdt_pin_partner

// ### testbench/standard_down_timer_bench.sv
`timescale 1ns/1ns
module standard_down_timer_bench
    import sdt_pkg::*;
;
    localparam logic [11:0] A_HI = {2'h0, SDT_IDX_HIGH, 2'h0};
    localparam logic [11:0] A_LO = {2'h0, SDT_IDX_LOW, 2'h0};
    localparam logic [11:0] A_PS = {2'h0, SDT_IDX_PSC, 2'h0};
    localparam logic [11:0] A_CT = {2'h0, SDT_IDX_CTRL, 2'h0};
    localparam logic [11:0] A_CT1 = {2'h0, SDT_IDX_CTRL + SDT_IDX_STRIDE,
        2'h0};
    logic mclk = 0;
    logic reset = 1;
    logic [11:0] s_axil_awaddr = '0, s_axil_araddr = '0;
    logic s_axil_awvalid = 0, s_axil_wvalid = 0, s_axil_bready = 0;
    logic s_axil_arvalid = 0, s_axil_rready = 0;
    logic [31:0] s_axil_wdata = '0, s_axil_rdata;
    logic [3:0] s_axil_wstrb = 4'hf;
    logic s_axil_awready, s_axil_wready, s_axil_bvalid;
    logic s_axil_arready, s_axil_rvalid;
    logic [1:0] s_axil_bresp, s_axil_rresp, r;
    logic oscillator_derived_clock = 0;
    logic [1:0] timer_input_pin, ext_irq_pin, timer_output_pin, irq_channel;
    logic pin0, ext0;
    logic [7:0] d;
    int mismatches = 0, samples_checked = 0, cyc = 0, irq_cnt = 0, n, base;
    assign timer_input_pin = {1'b1, pin0};
    assign ext_irq_pin = {1'b0, ext0};
    sdt_top sdt_top_i (.*);
    sdt_pin_partner sdt_pin_partner_i (.mclk(mclk), .pin(pin0),
        .ext_irq(ext0));
    always #10 mclk = ~mclk;
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (irq_channel[0] === 1'b1) irq_cnt <= irq_cnt + 1;
        if (cyc == 20000) begin
            mismatches++;
            test_done();
        end
    end
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Ready is sampled mid-cycle; it is comb and stable until the edge
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        logic ta, tw, tb;
        @(posedge mclk);
        s_axil_awaddr <= a;
        s_axil_wdata <= {24'h0, v};
        s_axil_awvalid <= 1;
        s_axil_wvalid <= 1;
        s_axil_bready <= 1;
        tb = 0;
        while (!tb) begin
            @(negedge mclk);
            ta = s_axil_awvalid && s_axil_awready;
            tw = s_axil_wvalid && s_axil_wready;
            tb = s_axil_bvalid;
            @(posedge mclk);
            if (ta) s_axil_awvalid <= 0;
            if (tw) s_axil_wvalid <= 0;
            if (tb) s_axil_bready <= 0;
        end
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [7:0] v,
        output logic [1:0] rs);
        logic ta, tr;
        @(posedge mclk);
        s_axil_araddr <= a;
        s_axil_arvalid <= 1;
        s_axil_rready <= 1;
        tr = 0;
        while (!tr) begin
            @(negedge mclk);
            ta = s_axil_arvalid && s_axil_arready;
            tr = s_axil_rvalid;
            v = s_axil_rdata[7:0];
            rs = s_axil_rresp;
            @(posedge mclk);
            if (ta) s_axil_arvalid <= 0;
            if (tr) s_axil_rready <= 0;
        end
    endtask : rd
    task automatic rc(input logic [11:0] a, input logic [7:0] exp);
        logic [7:0] v;
        logic [1:0] rs;
        rd(a, v, rs);
        chk({8'h0, v}, {8'h0, exp});
    endtask : rc
    task automatic wirq(output int cnt);
        cnt = 0;
        do begin
            @(negedge mclk);
            cnt++;
        end while (irq_channel[0] !== 1'b1 && cnt < 2000);
        if (cnt >= 2000) chk(16'h0, 16'h1);
    endtask : wirq
    task automatic test_done();
        $display("mismatches %0d samples_checked %0d", mismatches,
            samples_checked);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge mclk);
        reset <= 0;
        rc(A_HI, SDT_RST_HIGH);
        rc(A_LO, SDT_RST_LOW);
        rc(A_PS, SDT_RST_PSC);
        rc(A_CT, SDT_RST_CTRL);
        rc(A_CT1, SDT_RST_CTRL);
        rd(12'hc00, d, r);
        chk({14'h0, r}, {14'h0, SDT_RESP_SLVERR});
        wr(A_HI, 8'h00);
        wr(A_LO, 8'h03);
        wr(A_PS, 8'h01);
        rc(A_PS, 8'h01);
        wr(A_CT, 8'hc1);
        wirq(n);
        rc(A_CT, 8'h41);
        rc(A_LO, 8'h03);
        chk({15'h0, timer_output_pin[0]}, 16'h0);
        // Two prescale steps times four counts times four core clocks
        wr(A_CT, 8'h81);
        wirq(n);
        wirq(n);
        chk(16'(n), 16'd32);
        wr(A_CT, 8'h01);
        rd(A_LO, d, r);
        repeat (16) @(posedge mclk);
        rc(A_LO, d);
        wr(A_CT, 8'h82);
        wirq(n);
        chk({15'h0, timer_output_pin[0]}, 16'h0);
        wr(A_CT, 8'h83);
        wirq(n);
        chk({15'h0, timer_output_pin[0]}, 16'h1);
        wr(A_CT, 8'h82);
        wirq(n);
        wr(A_CT, 8'h80);
        @(negedge mclk);
        chk({15'h0, timer_output_pin[0]}, 16'h1);
        wr(A_CT, 8'h04);
        sdt_pin_partner_i.ext(1'b1);
        repeat (3) @(negedge mclk);
        chk({15'h0, irq_channel[0]}, 16'h1);
        sdt_pin_partner_i.ext(1'b0);
        repeat (3) @(negedge mclk);
        chk({15'h0, irq_channel[0]}, 16'h0);
        wr(A_LO, 8'h01);
        wr(A_PS, 8'h00);
        wr(A_CT, 8'h88);
        base = irq_cnt;
        sdt_pin_partner_i.fall(4);
        repeat (10) @(negedge mclk);
        chk(16'(irq_cnt - base), 16'd2);
        wr(A_CT, 8'h18);
        sdt_pin_partner_i.level(1'b0);
        wr(A_CT, 8'h98);
        base = irq_cnt;
        repeat (100) @(negedge mclk);
        chk(16'(irq_cnt - base), 16'd0);
        sdt_pin_partner_i.level(1'b1);
        wirq(n);
        chk(16'(n <= 12), 16'h1);
        wr(A_CT, 8'h28);
        wr(A_CT, 8'ha8);
        base = irq_cnt;
        repeat (40) @(negedge mclk);
        chk(16'(irq_cnt - base), 16'd0);
        sdt_pin_partner_i.fall(1);
        chk(16'(irq_cnt != base), 16'h1);
        test_done();
    end
endmodule : standard_down_timer_bench
